// ===== hdl/strap_capture.sv
// Reset-time strap capture, range decode and shared data pin routing.
// Assumes nrst is the full reset, synchronous to core_clk, held while straps settle.
`timescale 1ns/10ps
`default_nettype none
//Contract
// R1 - Byte interface strap sampled at reset release, fixed until next full reset.
// R2 - Three oversampling straps captured at reset release and held until next reset.
// R3 - Hardware or software mode decided from range pins at full reset.
// R4 - Hardware mode: range follows range pins live, no latching.
// R5 - Software mode: range pins latched and further changes ignored.
// R6 - Range code 00 software, 01 2.5V, 10 5V, 11 10V.
// R7 - Parallel mode: upper shared pins act as data bits 9 to 15.
// R8 - Software serial mode: data bit 10 pin is serial configuration input.
// R9 - Serial mode: data bit 12 pin drives serial output A.
// R10 - Serial mode: data bit 11 drives output B only if dual strap set.
// R11 - Single/dual strap at reset selects output A alone or both outputs.
// R12 - Host holds straps stable through full reset release.
module strap_capture
   import strap_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  nrst,
   input  wire logic [15:0]           bus_pin_in,
   input  wire logic [1:0]            range_pin,
   input  wire logic                  parallel_pin,
   input  wire logic [15:0]           par_out_data,
   input  wire logic                  par_out_en,
   input  wire logic                  ser_a_data,
   input  wire logic                  ser_b_data,
   output logic [15:0]                bus_pin_out,
   output logic [15:0]                bus_pin_oe_n,
   output logic [15:0]                par_in_data,
   output logic                       serial_config_in,
   output logic                       byte_interface_strap,
   output logic [2:0]                 oversampling_ratio,
   output logic                       software_mode,
   output strap_pkg::range_type       input_range,
   output strap_pkg::if_mode_type     interface_mode,
   output logic                       dual_output,
   output logic                       config_valid
);
   import strap_pkg::*;

   strap_sync_if sync ();

   strap_sync u_sync (
      .core_clk  (core_clk),
      .bus_pin   (bus_pin_in),
      .range_pin (range_pin),
      .par_pin   (parallel_pin),
      .sync      (sync)
   );

   function automatic range_type decode_range(input logic [1:0] code);
      case (code)
         RANGE_2V5: decode_range = RNG_2V5;
         RANGE_5V:  decode_range = RNG_5V;
         RANGE_10V: decode_range = RNG_10V;
         default:   decode_range = RNG_NONE;
      endcase
   endfunction

   // Capture state
   logic        in_reset_q, in_reset_d;
   logic        valid_q, valid_d;
   logic        byte_q, byte_d;
   logic [2:0]  osr_q, osr_d;
   logic        sw_q, sw_d;
   logic        dual_q, dual_d;
   logic        par_q, par_d;
   range_type   range_q, range_d;
   if_mode_type mode_q, mode_d;

   // Captured at the first clock after release; synchronised values are already
   // settled because the host holds straps through reset.
   logic capture;
   assign capture = in_reset_q && nrst; // R12

   always_comb begin
      in_reset_d = !nrst;
      valid_d    = valid_q;
      byte_d     = byte_q;
      osr_d      = osr_q;
      sw_d       = sw_q;
      dual_d     = dual_q;
      par_d      = par_q;
      range_d    = range_q;
      if (!nrst) begin
         valid_d = 1'b0;
         byte_d  = 1'b0;
         osr_d   = OSR_RESET;
         sw_d    = 1'b0;
         dual_d  = 1'b0;
         par_d   = 1'b0;
         range_d = RNG_NONE;
      end else if (capture) begin
         valid_d = 1'b1;
         byte_d  = sync.bus_in[POS_BYTE_SEL];                 // R1
         osr_d   = sync.bus_in[POS_OSR_LO +: OSR_WIDTH];      // R2
         sw_d    = (sync.range_sel == RANGE_SOFTWARE);        // R3
         dual_d  = !sync.bus_in[POS_SINGLE_OUT];              // R11
         par_d   = sync.par_sel;
         range_d = decode_range(sync.range_sel);              // R6
      end else if (valid_q && !sw_q) begin
         range_d = decode_range(sync.range_sel);              // R4
      end
      // Software mode keeps the captured range untouched  // R5
   end

   always_ff @(posedge core_clk) begin
      in_reset_q <= in_reset_d;
      valid_q    <= valid_d;
      byte_q     <= byte_d;
      osr_q      <= osr_d;
      sw_q       <= sw_d;
      dual_q     <= dual_d;
      par_q      <= par_d;
      range_q    <= range_d;
   end

   // Taken from the next strap values so the mode settles with config_valid;
   // a stale serial mode would drive output A for a cycle in parallel mode
   always_comb begin
      if (!par_d)
         mode_d = IF_SERIAL;
      else if (byte_d)
         mode_d = IF_BYTE;
      else
         mode_d = IF_PARALLEL;
   end

   always_ff @(posedge core_clk) begin
      mode_q <= mode_d;
   end

   // Pin routing, registered so every output leaves a flip-flop
   logic [15:0] out_q, out_d;
   logic [15:0] oe_n_q, oe_n_d;
   logic [15:0] pin_q, pin_d;
   logic        sdi_q, sdi_d;

   always_comb begin
      out_d  = '0;
      oe_n_d = BUS_OE_OFF;
      pin_d  = pin_q;
      sdi_d  = 1'b0;
      if (!nrst || !valid_q) begin
         // Pins stay released while straps are still being read
         pin_d = '0;
      end else begin
         case (mode_q)
            IF_PARALLEL: begin
               pin_d = sync.bus_in;                           // R7
               if (par_out_en) begin
                  out_d  = par_out_data;                      // R7
                  oe_n_d = '0;
               end
            end
            IF_BYTE: begin
               // Byte transfers use only the low lanes
               pin_d = {8'h00, sync.bus_in[7:0]};
               if (par_out_en) begin
                  out_d[7:0]  = par_out_data[7:0];
                  oe_n_d[7:0] = 8'h00;
               end
            end
            IF_SERIAL: begin
               pin_d = '0;
               out_d[POS_OUT_A]  = ser_a_data;                // R9
               oe_n_d[POS_OUT_A] = 1'b0;
               if (dual_q) begin
                  out_d[POS_OUT_B]  = ser_b_data;             // R10
                  oe_n_d[POS_OUT_B] = 1'b0;
               end
               if (sw_q)
                  sdi_d = sync.bus_in[POS_CFG_IN];            // R8
            end
            default: pin_d = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      out_q  <= out_d;
      oe_n_q <= oe_n_d;
      pin_q  <= pin_d;
      sdi_q  <= sdi_d;
   end

   assign bus_pin_out          = out_q;
   assign bus_pin_oe_n         = oe_n_q;
   assign par_in_data          = pin_q;
   assign serial_config_in     = sdi_q;
   assign byte_interface_strap = byte_q;
   assign oversampling_ratio   = osr_q;
   assign software_mode        = sw_q;
   assign input_range          = range_q;
   assign interface_mode       = mode_q;
   assign dual_output          = dual_q;
   assign config_valid         = valid_q;

   a_osr_held: assert property (@(posedge core_clk) disable iff (!nrst)
      valid_q && $past(valid_q) |-> $stable(osr_q))  // R2
      else $error("oversampling setting changed after capture");

   a_byte_held: assert property (@(posedge core_clk) disable iff (!nrst)
      valid_q && $past(valid_q) |-> $stable(byte_q))  // R1
      else $error("byte strap changed after capture");

   a_mode_held: assert property (@(posedge core_clk) disable iff (!nrst)
      valid_q && $past(valid_q) |-> $stable(sw_q))  // R3
      else $error("hw/sw mode changed after capture");

   a_sw_range_hold: assert property (@(posedge core_clk) disable iff (!nrst)
      sw_q && valid_q && $past(valid_q) |-> $stable(range_q))  // R5
      else $error("range moved in software mode");

   a_hw_range_live: assert property (@(posedge core_clk) disable iff (!nrst)
      valid_q && !sw_q && $past(valid_q) |-> range_q == $past(sync.range_sel))  // R4
      else $error("range does not follow pins in hardware mode");

   a_range_decode: assert property (@(posedge core_clk) disable iff (!nrst)
      valid_q |-> sw_q == (range_q == RNG_NONE))  // R6
      else $error("range decode mismatch");

   a_out_a_drive: assert property (@(posedge core_clk) disable iff (!nrst)
      valid_q && mode_q == IF_SERIAL ##1 mode_q == IF_SERIAL |->
      !oe_n_q[POS_OUT_A] && out_q[POS_OUT_A] == $past(ser_a_data))  // R9
      else $error("serial output A not driven");

   a_out_b_gate: assert property (@(posedge core_clk) disable iff (!nrst)
      valid_q && mode_q == IF_SERIAL ##1 mode_q == IF_SERIAL |->
      oe_n_q[POS_OUT_B] == !dual_q)  // R10
      else $error("serial output B enable wrong");

   a_par_upper: assert property (@(posedge core_clk) disable iff (!nrst)
      valid_q && mode_q == IF_PARALLEL && par_out_en |=>
      oe_n_q[UPPER_HI:UPPER_LO] == 7'h00)  // R7
      else $error("upper data pins not driven in parallel mode");
endmodule
`default_nettype wire

// ===== hdl/strap_pkg.sv
// Constants for the strap capture and shared pin routing block.
// Assumes a single core clock and a synchronous active-low full reset.
package strap_pkg;
   localparam int          BUS_WIDTH      = 16;
   localparam int          OSR_WIDTH      = 3;
   localparam int          RANGE_WIDTH    = 2;
   localparam int          SYNC_STAGES    = 2;
   // Shared pin positions on the parallel data bus
   localparam int          POS_SINGLE_OUT = 4;
   localparam int          POS_BYTE_SEL   = 9;
   localparam int          POS_CFG_IN     = 10;
   localparam int          POS_OUT_B      = 11;
   localparam int          POS_OUT_A      = 12;
   localparam int          POS_OSR_LO     = 13;
   localparam int          UPPER_LO       = 9;
   localparam int          UPPER_HI       = 15;
   // Range select encodings
   localparam logic [1:0]  RANGE_SOFTWARE = 2'h0;
   localparam logic [1:0]  RANGE_2V5      = 2'h1;
   localparam logic [1:0]  RANGE_5V       = 2'h2;
   localparam logic [1:0]  RANGE_10V      = 2'h3;
   // Reset values
   localparam logic [2:0]  OSR_RESET      = 3'h0;
   localparam logic [15:0] BUS_OE_OFF     = 16'hFFFF;

   typedef enum logic [1:0] {
      IF_SERIAL     = 2'h0,
      IF_PARALLEL   = 2'h1,
      IF_BYTE       = 2'h2
   } if_mode_type;

   typedef enum logic [1:0] {
      RNG_NONE = 2'h0,
      RNG_2V5  = 2'h1,
      RNG_5V   = 2'h2,
      RNG_10V  = 2'h3
   } range_type;
endpackage

// ===== hdl/strap_sync.sv
// Two-stage synchroniser for all asynchronous pin inputs.
// Assumes pins are quasi-static or tolerate two cycles of latency.
`timescale 1ns/10ps
`default_nettype none
module strap_sync
   import strap_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic [15:0] bus_pin,
   input  wire logic [1:0]  range_pin,
   input  wire logic        par_pin,
   strap_sync_if.src        sync
);
   logic [18:0] meta_q, meta_d;
   logic [18:0] stab_q, stab_d;

   // No reset here: straps held during reset must reach capture at release
   always_comb begin
      meta_d = {par_pin, range_pin, bus_pin};
      stab_d = meta_q;
   end

   // First stage feeds only the second
   always_ff @(posedge core_clk) begin
      meta_q <= meta_d;
      stab_q <= stab_d;
   end

   assign sync.bus_in    = stab_q[15:0];
   assign sync.range_sel = stab_q[17:16];
   assign sync.par_sel   = stab_q[18];
endmodule
`default_nettype wire

// ===== hdl/strap_sync_if.sv
// Interface carrying synchronised pin levels from the synchroniser to the core.
// Assumes both ends run on core_clk.
`timescale 1ns/10ps
`default_nettype none
interface strap_sync_if;
   logic [15:0] bus_in;
   logic [1:0]  range_sel;
   logic        par_sel;
   modport src (output bus_in, output range_sel, output par_sel);
   modport dst (input bus_in, input range_sel, input par_sel);
endinterface
`default_nettype wire

// ===== verif/strap_host_model.sv
// Host side of the shared pads: strap and data levels meet device drive.
// Assumes the device releases a pad by raising its active-low enable.
`timescale 1ns/10ps
`default_nettype none
module strap_host_model (
   input  wire logic [15:0] host_drive,
   input  wire logic [15:0] dev_out,
   input  wire logic [15:0] dev_oe_n,
   output logic      [15:0] pad
);
   // Straps stay on the pads until the device takes a pin over
   assign pad = (host_drive & dev_oe_n) | (dev_out & ~dev_oe_n);
endmodule
`default_nettype wire

// ===== verif/tb_reset_strap_capture_and_pin_mode.sv
// Self-checking bench for strap capture, range decode and pin routing.
// Assumes the capture block is the top and the host model sets the pads.
`timescale 1ns/10ps
`default_nettype none
module tb_reset_strap_capture_and_pin_mode;
   import strap_pkg::*;
   logic        core_clk, nrst, parallel_pin, par_out_en, ser_a_data, ser_b_data;
   logic [15:0] strap, pad, par_out_data, bus_pin_out, bus_pin_oe_n, par_in_data;
   logic [1:0]  range_pin;
   logic        serial_config_in, byte_interface_strap, software_mode;
   logic        dual_output, config_valid;
   logic [2:0]  oversampling_ratio;
   range_type   input_range;
   if_mode_type interface_mode;
   logic [17:0] notes[$];
   logic [17:0] n;
   int          failures, compares;
   int          seed = 32'hE7EBE0BA;
   event        look;

   strap_host_model strap_host_model_i (.host_drive(strap), .dev_out(bus_pin_out),
      .dev_oe_n(bus_pin_oe_n), .pad(pad));
   strap_capture strap_capture_i (.core_clk, .nrst, .bus_pin_in(pad), .range_pin,
      .parallel_pin, .par_out_data, .par_out_en, .ser_a_data, .ser_b_data,
      .bus_pin_out, .bus_pin_oe_n, .par_in_data, .serial_config_in,
      .byte_interface_strap, .oversampling_ratio, .software_mode, .input_range,
      .interface_mode, .dual_output, .config_valid);

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Notes are judged once the launching edge has settled
   always begin
      @look;
      #1;
      while (notes.size() > 0) begin
         n = notes.pop_front();
         case (n[17:16])
            2'h0: check({6'h0, byte_interface_strap, oversampling_ratio, software_mode,
                  input_range, interface_mode, config_valid}, n[15:0]);
            2'h1: check({10'h0, bus_pin_oe_n[12], bus_pin_out[12], bus_pin_oe_n[11],
                  bus_pin_out[11] & dual_output, dual_output, serial_config_in},
                  n[15:0]);
            2'h2: check({2'h0, bus_pin_oe_n[15:9], bus_pin_out[15:9]}, n[15:0]);
            default: check(par_in_data, n[15:0]);
         endcase
      end
   end

   // One full reset with random straps, then late strap and range changes
   task automatic run(input logic par, input logic [1:0] rng);
      logic [15:0] s;
      logic [15:0] d;
      logic [1:0]  rn;
      logic [1:0]  mode;
      int          k;
      s = 16'($random(seed));
      d = 16'($random(seed));
      rn = (d[1:0] == 2'h0) ? 2'h2 : d[1:0];
      s[9] = s[9] & par;
      mode = par ? (s[9] ? IF_BYTE : IF_PARALLEL) : IF_SERIAL;
      @(posedge core_clk);
      nrst <= 1'b0;
      strap <= s;
      parallel_pin <= par;
      range_pin <= rng;
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      for (k = 0; k < 50 && config_valid !== 1'b1; k++) @(posedge core_clk);
      if (k == 50) begin
         failures++;
         final_report();
      end
      ser_a_data <= d[2];
      ser_b_data <= d[3];
      par_out_en <= 1'b1;
      par_out_data <= d;
      repeat (4) @(posedge core_clk);
      notes.push_back({2'h0, 6'h0, s[9], s[15:13], rng == 2'h0, rng, mode, 1'b1});
      if (!par)
         notes.push_back({2'h1, 10'h0, 1'b0, d[2], s[4], d[3] & ~s[4], ~s[4],
            (rng == 2'h0) & s[10]});
      else
         notes.push_back({2'h2, 2'h0, s[9] ? 14'h3F80 : {7'h00, d[15:9]}});
      notes.push_back({2'h3, par ? (s[9] ? {8'h00, d[7:0]} : d) : 16'h0000});
      -> look;
      // Late changes must not reach captured settings
      strap <= ~s;
      range_pin <= (rng == 2'h0) ? 2'h3 : rn;
      repeat (5) @(posedge core_clk);
      notes.push_back({2'h0, 6'h0, s[9], s[15:13], rng == 2'h0,
         (rng == 2'h0) ? 2'h0 : rn, mode, 1'b1});
      -> look;
      par_out_en <= 1'b0;
   endtask

   initial begin
      nrst = 1'b0;
      strap = 16'h0000;
      parallel_pin = 1'b0;
      range_pin = 2'h0;
      par_out_data = 16'h0000;
      par_out_en = 1'b0;
      ser_a_data = 1'b0;
      ser_b_data = 1'b0;
      failures = 0;
      compares = 0;
      for (int i = 0; i < 16; i++) begin
         run(i[0], i[2:1]);
      end
      repeat (2) @(posedge core_clk);
      final_report();
   end
endmodule
`default_nettype wire
